/* File: logic/rfsc_pkg.sv */
// package with register map, field layout and reset values for the radio front-end bank
package rfsc_pkg;
	// ------------------------------------------------------------------
	// register indexes; the byte address of each register is four times its index
	// ------------------------------------------------------------------
	localparam logic [15:0] IDX_RX_FRONTEND_BIAS       = 16'hdf1a;
	localparam logic [15:0] IDX_TX_FRONTEND_BIAS       = 16'hdf1b;
	localparam logic [15:0] IDX_SYNTH_CHARGE_PUMP_CAL  = 16'hdf1c;
	localparam logic [15:0] IDX_SYNTH_VCO_CURRENT_CAL  = 16'hdf1d;
	localparam logic [17:0] ADDR_RX_FRONTEND_BIAS      = {IDX_RX_FRONTEND_BIAS, 2'h0};
	localparam logic [17:0] ADDR_TX_FRONTEND_BIAS      = {IDX_TX_FRONTEND_BIAS, 2'h0};
	localparam logic [17:0] ADDR_SYNTH_CHARGE_PUMP_CAL = {IDX_SYNTH_CHARGE_PUMP_CAL, 2'h0};
	localparam logic [17:0] ADDR_SYNTH_VCO_CURRENT_CAL = {IDX_SYNTH_VCO_CURRENT_CAL, 2'h0};
	localparam int          ADDR_W                     = 18;

	// ------------------------------------------------------------------
	// reset values and writable masks
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_RX_FRONTEND_BIAS      = 8'h56;
	localparam logic [7:0] RST_TX_FRONTEND_BIAS      = 8'h10;
	localparam logic [7:0] RST_SYNTH_CHARGE_PUMP_CAL = 8'ha9;
	localparam logic [7:0] RST_SYNTH_VCO_CURRENT_CAL = 8'h0a;
	localparam logic [7:0] MASK_RX_FRONTEND_BIAS      = 8'hff;
	localparam logic [7:0] MASK_TX_FRONTEND_BIAS      = 8'h37;
	localparam logic [7:0] MASK_SYNTH_CHARGE_PUMP_CAL = 8'hff;
	localparam logic [7:0] MASK_SYNTH_VCO_CURRENT_CAL = 8'h3f;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// field layouts
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] rx_amp_bias;
		logic [1:0] amp_to_mixer_bias;
		logic [1:0] rx_lo_buffer_bias;
		logic [1:0] mixer_bias;
	} rfsc_rx_bias_t;

	typedef struct packed {
		logic [1:0] tx_lo_buffer_bias;
		logic [2:0] tx_reserved;
	} rfsc_tx_bias_t;

	typedef struct packed {
		logic [1:0] cal_config;
		logic [1:0] charge_pump_cal_stage_on;
		logic [3:0] charge_pump_current;
	} rfsc_cp_cal_t;

	typedef struct packed {
		logic       high_oscillator_select;
		logic [4:0] vco_current;
	} rfsc_vco_cal_t;
endpackage : rfsc_pkg

/* File: logic/rfsc_regs.sv */
// AXI4-Lite register bank for the radio front-end bias and synthesizer calibration
`timescale 1ns/1ps
module rfsc_regs (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_ARST_N,
	// deep sleep wake-up pulse from power control (same clock)
	input  wire logic        I_DEEP_SLEEP_WAKE,
	// axi4-lite slave
	input  wire logic [17:0] I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	input  wire logic [17:0] I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	// fields to the analog front end and synthesizer
	output rfsc_pkg::rfsc_rx_bias_t  O_RX_BIAS,
	output rfsc_pkg::rfsc_tx_bias_t  O_TX_BIAS,
	output rfsc_pkg::rfsc_cp_cal_t   O_CP_CAL,
	output rfsc_pkg::rfsc_vco_cal_t  O_VCO_CAL,
	output logic                     O_CP_CAL_STAGE_SKIP
);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	logic [7:0]  rx_r;
	logic [7:0]  tx_r;
	logic [7:0]  cp_r;
	logic [7:0]  vco_r;
	logic [17:0] awaddr_r;
	logic        aw_held_r;
	logic [7:0]  wdata_r;
	logic        wlane_r;
	logic        w_held_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [7:0]  rdata_r;
	logic [1:0]  rresp_r;
	logic        aw_rdy_r;
	logic        w_rdy_r;
	logic        ar_rdy_r;
	logic        skip_r;
	// field view of the next charge pump value, and the skip flag's reset value
	rfsc_pkg::rfsc_cp_cal_t cp_nxt_f;
	localparam rfsc_pkg::rfsc_cp_cal_t CP_RST_F = rfsc_pkg::RST_SYNTH_CHARGE_PUMP_CAL;
	localparam logic                   SKIP_RST = (CP_RST_F.charge_pump_cal_stage_on == 2'h0);

	// ------------------------------------------------------------------
	// write channel decode
	// ------------------------------------------------------------------
	// a channel is ready only while its holding slot is empty and no response pends;
	// readiness is worked out one cycle ahead and kept in a flop
	wire        aw_rdy   = aw_rdy_r;
	wire        w_rdy    = w_rdy_r;
	wire        aw_fire  = I_AWVALID && aw_rdy;
	wire        w_fire   = I_WVALID && w_rdy;
	wire        have_aw  = aw_held_r || aw_fire;
	wire        have_w   = w_held_r || w_fire;
	wire        wr_go    = have_aw && have_w;
	wire [17:0] wr_addr  = aw_held_r ? awaddr_r : I_AWADDR;
	wire [7:0]  wr_data  = w_held_r ? wdata_r : I_WDATA[7:0];
	wire        wr_lane  = w_held_r ? wlane_r : I_WSTRB[0];
	wire        wr_rx    = wr_addr == rfsc_pkg::ADDR_RX_FRONTEND_BIAS;
	wire        wr_tx    = wr_addr == rfsc_pkg::ADDR_TX_FRONTEND_BIAS;
	wire        wr_cp    = wr_addr == rfsc_pkg::ADDR_SYNTH_CHARGE_PUMP_CAL;
	wire        wr_vco   = wr_addr == rfsc_pkg::ADDR_SYNTH_VCO_CURRENT_CAL;
	wire        wr_hit   = wr_rx || wr_tx || wr_cp || wr_vco;
	wire        wr_en    = wr_go && wr_lane;
	// next state of the holding slots and of the write response flag
	wire        aw_held_nxt = have_aw && !wr_go;
	wire        w_held_nxt  = have_w && !wr_go;
	wire        bvalid_nxt  = wr_go || (bvalid_r && !I_BREADY);
	wire        aw_rdy_nxt  = !aw_held_nxt && !bvalid_nxt;
	wire        w_rdy_nxt   = !w_held_nxt && !bvalid_nxt;

	// next values: unused bits masked off so they never store
	wire [7:0] rx_nxt  = (wr_en && wr_rx) ? (wr_data & rfsc_pkg::MASK_RX_FRONTEND_BIAS) : rx_r;
	wire [7:0] tx_nxt  = (wr_en && wr_tx) ? (wr_data & rfsc_pkg::MASK_TX_FRONTEND_BIAS) : tx_r;
	wire [7:0] vco_nxt = (wr_en && wr_vco) ? (wr_data & rfsc_pkg::MASK_SYNTH_VCO_CURRENT_CAL)
		: vco_r;
	// wake from deep sleep wins over a write in the same cycle
	wire [7:0] cp_nxt  = I_DEEP_SLEEP_WAKE ? rfsc_pkg::RST_SYNTH_CHARGE_PUMP_CAL
		: (wr_en && wr_cp) ? (wr_data & rfsc_pkg::MASK_SYNTH_CHARGE_PUMP_CAL) : cp_r;
	// skip flag follows the stage field of the value about to be stored
	assign cp_nxt_f = cp_nxt;
	wire       skip_nxt = (cp_nxt_f.charge_pump_cal_stage_on == 2'h0);

	// ------------------------------------------------------------------
	// read channel decode
	// ------------------------------------------------------------------
	// a new read is taken only once the previous answer has been accepted
	wire       ar_rdy  = ar_rdy_r;
	wire       ar_fire = I_ARVALID && ar_rdy;
	wire       rvalid_nxt = ar_fire || (rvalid_r && !I_RREADY);
	wire       rd_rx   = I_ARADDR == rfsc_pkg::ADDR_RX_FRONTEND_BIAS;
	wire       rd_tx   = I_ARADDR == rfsc_pkg::ADDR_TX_FRONTEND_BIAS;
	wire       rd_cp   = I_ARADDR == rfsc_pkg::ADDR_SYNTH_CHARGE_PUMP_CAL;
	wire       rd_vco  = I_ARADDR == rfsc_pkg::ADDR_SYNTH_VCO_CURRENT_CAL;
	wire       rd_hit  = rd_rx || rd_tx || rd_cp || rd_vco;
	// mask on read too so unused bits are zero in every case
	wire [7:0] rd_mux  = rd_rx ? (rx_r & rfsc_pkg::MASK_RX_FRONTEND_BIAS)
		: rd_tx ? (tx_r & rfsc_pkg::MASK_TX_FRONTEND_BIAS)
		: rd_cp ? (cp_r & rfsc_pkg::MASK_SYNTH_CHARGE_PUMP_CAL)
		: rd_vco ? (vco_r & rfsc_pkg::MASK_SYNTH_VCO_CURRENT_CAL) : 8'h00;

	// ------------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------------
	// field resets and writes of saved calibration values
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rx_r  <= rfsc_pkg::RST_RX_FRONTEND_BIAS;
			tx_r  <= rfsc_pkg::RST_TX_FRONTEND_BIAS;
			cp_r  <= rfsc_pkg::RST_SYNTH_CHARGE_PUMP_CAL;
			vco_r <= rfsc_pkg::RST_SYNTH_VCO_CURRENT_CAL;
		end else begin
			rx_r  <= rx_nxt;
			tx_r  <= tx_nxt;
			cp_r  <= cp_nxt;
			vco_r <= vco_nxt;
		end
	end

	// holding slots for an address or data beat that arrives alone,
	// so the two write channels may be taken in either order
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= 18'h00000;
			wdata_r   <= 8'h00;
			wlane_r   <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r  <= w_held_nxt;
			if (aw_fire) begin
				awaddr_r <= I_AWADDR;
			end
			if (w_fire) begin
				wdata_r <= I_WDATA[7:0];
				wlane_r <= I_WSTRB[0];
			end
		end
	end

	// write response
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			bvalid_r <= 1'b0;
			bresp_r  <= rfsc_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? rfsc_pkg::RESP_OKAY : rfsc_pkg::RESP_SLVERR;
		end else if (I_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	// read response
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 8'h00;
			rresp_r  <= rfsc_pkg::RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= rd_hit ? rfsc_pkg::RESP_OKAY : rfsc_pkg::RESP_SLVERR;
		end else if (I_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	// ready and skip flags kept in flops so every output leaves a register
	always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			aw_rdy_r <= 1'b1;
			w_rdy_r  <= 1'b1;
			ar_rdy_r <= 1'b1;
			skip_r   <= SKIP_RST;
		end else begin
			aw_rdy_r <= aw_rdy_nxt;
			w_rdy_r  <= w_rdy_nxt;
			ar_rdy_r <= !rvalid_nxt;
			skip_r   <= skip_nxt;
		end
	end

	// ------------------------------------------------------------------
	// outputs (all from flip-flops)
	// ------------------------------------------------------------------
	assign O_AWREADY = aw_rdy;
	assign O_WREADY  = w_rdy;
	assign O_BVALID  = bvalid_r;
	assign O_BRESP   = bresp_r;
	assign O_ARREADY = ar_rdy;
	assign O_RVALID  = rvalid_r;
	assign O_RRESP   = rresp_r;
	assign O_RDATA   = {24'h000000, rdata_r};
	assign O_RX_BIAS = rx_r;
	assign O_TX_BIAS = {tx_r[5:4], tx_r[2:0]};
	assign O_CP_CAL  = cp_r;
	assign O_VCO_CAL = vco_r[5:0];
	// zero in the stage field tells the calibration engine to skip that stage
	assign O_CP_CAL_STAGE_SKIP = skip_r;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_wake;
		I_DEEP_SLEEP_WAKE;
	endsequence

	// a write that lands in the charge pump register
	sequence s_cp_write;
		wr_en && wr_cp;
	endsequence

	// both beats of a write have been had at this edge
	sequence s_write_done;
		wr_go;
	endsequence

	// the response stands and both write channels are refused meanwhile
	sequence s_resp_stands;
		O_BVALID && !O_AWREADY && !O_WREADY;
	endsequence

	a_cp_wake_reset: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		s_wake |=> cp_r == rfsc_pkg::RST_SYNTH_CHARGE_PUMP_CAL)
		else $error("charge pump cal not reset after deep sleep wake");
	a_tx_unused_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		tx_r[7:6] == 2'h0 && tx_r[3] == 1'b0)
		else $error("tx unused bits nonzero");
	a_vco_unused_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		vco_r[7:6] == 2'h0)
		else $error("vco unused bits nonzero");
	a_rdata_upper_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_RVALID |-> O_RDATA[31:8] == 24'h000000)
		else $error("read data upper bits nonzero");
	a_cp_write_lands: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_en && wr_cp && !I_DEEP_SLEEP_WAKE |=> cp_r == $past(wr_data))
		else $error("saved charge pump value not stored");
	a_vco_write_lands: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_en && wr_vco |=> vco_r[5:0] == $past(wr_data[5:0]))
		else $error("vco value not stored");
	a_skip_tracks: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_CP_CAL_STAGE_SKIP == (O_CP_CAL.charge_pump_cal_stage_on == 2'h0))
		else $error("skip flag disagrees with stage field");
	a_rx_write_lands: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_en && wr_rx |=> rx_r == $past(wr_data))
		else $error("rx bias value not stored");
	a_read_answers: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		ar_fire |=> O_RVALID && O_RDATA[7:0] == $past(rd_mux))
		else $error("read answer late or wrong");
	a_bresp_after: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		s_write_done |=> s_resp_stands)
		else $error("write response missing");

	// wake and a software write in one cycle: the reset value wins
	a_wake_beats_write: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		s_wake ##0 s_cp_write |=> cp_r == rfsc_pkg::RST_SYNTH_CHARGE_PUMP_CAL)
		else $error("write beat deep sleep wake");

	// registers keep their value while nothing writes them and, for the charge pump one, no wake comes
	a_rx_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		!(wr_en && wr_rx) |=> $stable(rx_r))
		else $error("rx bias changed without a write");
	a_tx_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		!(wr_en && wr_tx) |=> $stable(tx_r))
		else $error("tx bias changed without a write");
	a_cp_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		!(wr_en && wr_cp) && !I_DEEP_SLEEP_WAKE |=> $stable(cp_r))
		else $error("charge pump cal changed without a write");
	a_vco_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		!(wr_en && wr_vco) |=> $stable(vco_r))
		else $error("vco cal changed without a write");

	// ready flops agree with the holding slots and pending answers
	a_aw_ready_flop: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_AWREADY == (!aw_held_r && !bvalid_r))
		else $error("address ready out of step");
	a_w_ready_flop: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_WREADY == (!w_held_r && !bvalid_r))
		else $error("data ready out of step");
	a_ar_ready_flop: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_ARREADY == !rvalid_r)
		else $error("read ready out of step");
	a_one_slot: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		!(aw_held_r && w_held_r))
		else $error("both write beats left waiting");

	// answers stand unchanged until the master takes them
	a_bvalid_stands: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped early");
	a_rvalid_stands: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read answer dropped early");

	// mapped places answer okay, unmapped ones with an error and zero data
	a_bresp_ok: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_go && wr_hit |=> O_BRESP == rfsc_pkg::RESP_OKAY)
		else $error("mapped write refused");
	a_bresp_unmapped: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_go && !wr_hit |=> O_BRESP == rfsc_pkg::RESP_SLVERR)
		else $error("unmapped write not refused");
	a_rresp_ok: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		ar_fire && rd_hit |=> O_RRESP == rfsc_pkg::RESP_OKAY)
		else $error("mapped read refused");
	a_rresp_unmapped: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		ar_fire && !rd_hit |=> O_RRESP == rfsc_pkg::RESP_SLVERR && O_RDATA == 32'h00000000)
		else $error("unmapped read not refused");

	// stored tx value keeps only its writable bits; an empty strobe stores nothing
	a_tx_write_lands: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_en && wr_tx |=> tx_r == ($past(wr_data) & rfsc_pkg::MASK_TX_FRONTEND_BIAS))
		else $error("tx bias value not stored");
	a_lane_gate: assert property (@(posedge I_CORE_CLK) disable iff (!I_ARST_N)
		wr_go && !wr_lane |=> $stable(rx_r) && $stable(tx_r) && $stable(vco_r))
		else $error("write without byte strobe stored");

endmodule : rfsc_regs

/* File: tb/tb_rfsc_regs.sv */
// self-checking bench for the radio front-end bias and synthesizer calibration registers
`timescale 1ns/1ps
module tb_rfsc_regs;
	// ------------------------------------------------------------------
	// byte addresses, response codes and bench signals
	// ------------------------------------------------------------------
	localparam logic [17:0] A_RX = rfsc_pkg::ADDR_RX_FRONTEND_BIAS;
	localparam logic [17:0] A_TX = rfsc_pkg::ADDR_TX_FRONTEND_BIAS;
	localparam logic [17:0] A_CP = rfsc_pkg::ADDR_SYNTH_CHARGE_PUMP_CAL;
	localparam logic [17:0] A_VC = rfsc_pkg::ADDR_SYNTH_VCO_CURRENT_CAL;
	localparam logic [17:0] A_NO = 18'h00004;
	localparam logic [1:0]  OK   = rfsc_pkg::RESP_OKAY;
	localparam logic [1:0]  ERR  = rfsc_pkg::RESP_SLVERR;
	logic                    clk, rst_n, wake;
	logic [17:0]             aw_addr, ar_addr;
	logic                    aw_v, w_v, b_rdy, ar_v, r_rdy;
	logic [31:0]             w_data, r_data;
	logic [3:0]              w_strb;
	logic                    aw_rdy, w_rdy, b_v, ar_rdy, r_v, skip;
	logic [1:0]              b_resp, r_resp;
	rfsc_pkg::rfsc_rx_bias_t rx_bias;
	rfsc_pkg::rfsc_tx_bias_t tx_bias;
	rfsc_pkg::rfsc_cp_cal_t  cp_cal;
	rfsc_pkg::rfsc_vco_cal_t vco_cal;
	int                      fails, n_checks;

	rfsc_regs u_dut (
		.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_DEEP_SLEEP_WAKE(wake),
		.I_AWADDR(aw_addr), .I_AWVALID(aw_v), .O_AWREADY(aw_rdy),
		.I_WDATA(w_data), .I_WSTRB(w_strb), .I_WVALID(w_v), .O_WREADY(w_rdy),
		.O_BRESP(b_resp), .O_BVALID(b_v), .I_BREADY(b_rdy),
		.I_ARADDR(ar_addr), .I_ARVALID(ar_v), .O_ARREADY(ar_rdy),
		.O_RDATA(r_data), .O_RRESP(r_resp), .O_RVALID(r_v), .I_RREADY(r_rdy),
		.O_RX_BIAS(rx_bias), .O_TX_BIAS(tx_bias), .O_CP_CAL(cp_cal),
		.O_VCO_CAL(vco_cal), .O_CP_CAL_STAGE_SKIP(skip)
	);

	// 125 MHz core clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// compare, bus and closing tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// write: address and data offered together, each dropped once taken
	task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic [3:0] s,
			input logic [1:0] er);
		logic done = 1'b0;
		@(posedge clk);
		aw_addr <= a;
		w_data  <= {24'h0, d};
		w_strb  <= s;
		aw_v    <= 1'b1;
		w_v     <= 1'b1;
		b_rdy   <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (aw_v && aw_rdy)
				aw_v <= 1'b0;
			if (w_v && w_rdy)
				w_v <= 1'b0;
			if (b_rdy && b_v) begin
				done = 1'b1;
				b_rdy <= 1'b0;
				chk({30'h0, b_resp}, {30'h0, er});
			end
		end
	endtask : wr

	// read: data and response taken at the edge where rvalid is seen
	task automatic rd(input logic [17:0] a, input logic [7:0] d, input logic [1:0] er);
		logic done = 1'b0;
		@(posedge clk);
		ar_addr <= a;
		ar_v    <= 1'b1;
		r_rdy   <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (ar_v && ar_rdy)
				ar_v <= 1'b0;
			if (r_rdy && r_v) begin
				done = 1'b1;
				r_rdy <= 1'b0;
				chk(r_data, {24'h0, d});
				chk({30'h0, r_resp}, {30'h0, er});
			end
		end
	endtask : rd

	task automatic close_out;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------------
	// test sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		{rst_n, wake, aw_v, w_v, b_rdy, ar_v, r_rdy} <= 7'h0;
		{aw_addr, ar_addr, w_data, w_strb} <= 72'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// reset values of every register
		rd(A_RX, 8'h56, OK);
		rd(A_TX, 8'h10, OK);
		rd(A_CP, 8'ha9, OK);
		rd(A_VC, 8'h0a, OK);
		chk({31'h0, skip}, 32'h0);
		// unused bits dropped, reserved tx bits kept at zero
		wr(A_RX, 8'hff, 4'hf, OK);
		rd(A_RX, 8'hff, OK);
		wr(A_TX, 8'hf8, 4'hf, OK);
		rd(A_TX, 8'h30, OK);
		chk({27'h0, tx_bias}, 32'h18);
		wr(A_VC, 8'hdf, 4'hf, OK);
		rd(A_VC, 8'h1f, OK);
		// stage field at zero skips charge pump calibration
		wr(A_CP, 8'hcf, 4'hf, OK);
		chk({31'h0, skip}, 32'h1);
		rd(A_CP, 8'hcf, OK);
		// saved results restored back to back
		wr(A_CP, 8'h5c, 4'hf, OK);
		wr(A_VC, 8'h11, 4'hf, OK);
		rd(A_CP, 8'h5c, OK);
		rd(A_VC, 8'h11, OK);
		chk({24'h0, cp_cal}, 32'h5c);
		chk({26'h0, vco_cal}, 32'h11);
		// empty strobe stores nothing, unmapped place answers with error
		wr(A_RX, 8'h00, 4'h0, OK);
		rd(A_RX, 8'hff, OK);
		chk({24'h0, rx_bias}, 32'hff);
		wr(A_NO, 8'h55, 4'hf, ERR);
		rd(A_NO, 8'h00, ERR);
		// wake from deep sleep restores only the charge pump register
		@(posedge clk);
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		rd(A_CP, 8'ha9, OK);
		chk({31'h0, skip}, 32'h0);
		rd(A_VC, 8'h11, OK);
		rd(A_RX, 8'hff, OK);
		// wake in the very cycle a saved value lands: the reset value wins
		fork
			wr(A_CP, 8'h5c, 4'hf, OK);
			begin
				@(posedge clk);
				wake <= 1'b1;
				@(posedge clk);
				wake <= 1'b0;
			end
		join
		rd(A_CP, 8'ha9, OK);
		close_out;
	end

	// cut a hang short well beyond the under a hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		close_out;
	end
endmodule : tb_rfsc_regs
